//--- inc/serial_dma_pkg.sv
/*
  Constants, register map and carrier types of the serial-port DMA channel block.
  Assumes one processor clock and word-addressed register ports as printed in the map.
*/
// How it works
// - Comparison and match polarity both set: accept only words matching the key.
// - Bit n of the slot compare select turns on key comparison for slot n.
// - Mask bit clear compares that bit; mask bit set leaves it out.
// - DMA off: interrupt per received word or per transmit word start.
// - Single-word and block transfers share one interrupt per channel.
// - Eight serial DMA channels: two receive and two transmit per port.
// - Serial channels win over external-port channels in the same cycle.
// - Fixed priority: receive 0A, 0B, 1A, 1B, transmit likewise, then external 0, 1.
// - Transfers are 32-bit; packing joins two short serial words per transfer.
// - Serial words of 3 to 32 bits still give 32-bit DMA words.
// - With packing, one interrupt per packed 32-bit word.
// - Each channel has its own DMA enable and chain enable control bit; the code has one unused CHAIN_EN_BIT per control register.
// - Parameter registers are writable by local core and external processor.
// - Enabled channel stores received words, fetches words when port ready.
// - Index gains the signed step after each transfer.
// - Count drops per transfer; at zero raise interrupt and disable channel.
// - Each channel has a chain pointer and a free spare word register.
// - Key comparison only in multislot mode; otherwise all words accepted.
// - Polarity 0 with comparison on: accept only non-matching words.
package serial_dma_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_SER = 8;
  localparam int NUM_ALL = 10;

  // ****************************************
  // Register map (word addresses)
  // ****************************************
  localparam logic [7:0] PAR_BASE [NUM_SER] = '{8'h60, 8'h30, 8'h68, 8'h38, 8'h70, 8'h50, 8'h78, 8'h58};
  localparam logic [7:0] PAR_NUM = 8'h05;
  localparam logic [2:0] PAR_INDEX = 3'h0;
  localparam logic [2:0] PAR_STEP = 3'h1;
  localparam logic [2:0] PAR_COUNT = 3'h2;
  localparam logic [2:0] PAR_CHAIN = 3'h3;
  localparam logic [2:0] PAR_SPARE = 3'h4;
  localparam logic [7:0] CTL_ADDR = 8'h00;
  localparam logic [7:0] KEY_ADDR = 8'h04;
  localparam logic [7:0] KMASK_ADDR = 8'h06;
  localparam logic [7:0] CSEL_ADDR = 8'h08;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int DMA_EN_BIT = 0;
  localparam int CHAIN_EN_BIT = 2;
  localparam int PACK_BIT = 4;
  localparam int LEN_LO = 5;
  localparam int LEN_HI = 9;
  localparam int KEY_COMPARE_ENABLE_BIT = 10;
  localparam int KEY_MATCH_POLARITY_BIT = 11;
  localparam int MULTISLOT_ENABLE_BIT = 12;
  localparam logic [4:0] PACK_MAX_LEN_M1 = 5'h0F;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] CTL_RST = 32'h000003E0;
  localparam logic [31:0] PAR_RST = 32'h00000000;
  localparam logic [31:0] KEY_RST = 32'h00000000;
  localparam logic [31:0] KMASK_RST = 32'h00000000;
  localparam logic [31:0] CSEL_RST = 32'h00000000;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [31:0] data;
  } reg_wr_t;

  typedef struct packed {
    logic valid;
    logic [4:0] slot;
    logic [31:0] data;
  } rx_word_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_t;

endpackage

//--- verilog/serial_dma_channels.sv
/*
  Serial-port DMA channels: receive key comparison, packing, channel arbitration,
  parameter registers and per-channel interrupts.
  Assumes serial ports and memory on SYS_CLK; memory answers a read with MEM_RVALID.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_dma_channels
  import serial_dma_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // Register ports
  input wire reg_wr_t CORE_WR,
  input wire reg_wr_t EXT_WR,
  input wire logic RD_EN,
  input wire logic [7:0] RD_ADDR,
  output logic [31:0] RD_DATA,
  // Serial port side
  input wire rx_word_t [3:0] RX_WORD,
  input wire logic [3:0] TX_READY,
  input wire logic [3:0] TX_START,
  output logic [3:0] TX_LOAD,
  output logic [31:0] TX_DATA,
  // Arbitration and memory
  input wire logic [1:0] EP_REQ,
  output logic [9:0] DMA_GRANT,
  output mem_req_t MEM_REQ,
  input wire logic [31:0] MEM_RDATA,
  input wire logic MEM_RVALID,
  // Interrupts
  output logic [7:0] CHAN_IRQ
);

  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_FETCH = 2'b10} eng_state_t;

  function automatic logic [31:0] len_mask(input logic [4:0] len_m1);
    return 32'hFFFFFFFF >> (5'h1F - len_m1);
  endfunction

  function automatic logic [6:0] par_dec(input logic [7:0] a);
    logic [6:0] r;
    logic [7:0] off;
    r = 7'h00;
    for (int c = 0; c < NUM_SER; c++) begin
      off = a - PAR_BASE[c];
      if (off < PAR_NUM) begin
        r = {1'b1, 3'(c), off[2:0]};
      end
    end
    return r;
  endfunction

  function automatic logic [3:0] first_set(input logic [9:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int k = NUM_ALL - 1; k >= 0; k--) begin
      if (v[k]) begin
        r = 4'(k);
      end
    end
    return r;
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [31:0] par_ff [NUM_SER][5];
  logic [31:0] nxt_par [NUM_SER][5];
  logic [31:0] ctl_ff [4];
  logic [31:0] nxt_ctl [4];
  logic [31:0] key_ff [2];
  logic [31:0] nxt_key [2];
  logic [31:0] kmask_ff [2];
  logic [31:0] nxt_kmask [2];
  logic [31:0] csel_ff [2];
  logic [31:0] nxt_csel [2];
  eng_state_t state_ff, nxt_state;
  logic [1:0] fetch_ff, nxt_fetch;
  logic [9:0] grant_ff, nxt_grant;
  mem_req_t mem_ff, nxt_mem;
  logic [3:0] txload_ff, nxt_txload;
  logic [31:0] txdata_ff, nxt_txdata;
  logic [7:0] irq_ff, nxt_irq;
  logic [31:0] rd_ff, nxt_rd;
  logic [31:0] rx_hold_ff [4];
  logic [31:0] nxt_hold [4];
  logic [15:0] rx_lo_ff [4];
  logic [15:0] nxt_lo [4];
  logic [3:0] rx_full_ff, nxt_full;
  logic [3:0] rx_half_ff, nxt_half;
  logic [3:0] tx_half_ff, nxt_txhalf;
  logic [3:0] rx_irq, tx_irq, take_rx, cmp_on, match, acc, rej;
  logic [9:0] pend;
  logic [3:0] pick;
  logic [31:0] cur_idx, cur_step, cur_cnt;

  // ****************************************
  // Receive acceptance, packing, single-word interrupts
  // ****************************************
  always_comb begin
    logic [31:0] c;
    logic [31:0] ct;
    logic [31:0] d;
    logic pk;
    logic tpk;
    c = 32'h0;
    ct = 32'h0;
    d = 32'h0;
    pk = 1'b0;
    tpk = 1'b0;
    nxt_hold = rx_hold_ff;
    nxt_lo = rx_lo_ff;
    nxt_full = rx_full_ff;
    nxt_half = rx_half_ff;
    nxt_txhalf = tx_half_ff;
    rx_irq = 4'h0;
    tx_irq = 4'h0;
    cmp_on = 4'h0;
    match = 4'h0;
    acc = 4'h0;
    rej = 4'h0;
    for (int i = 0; i < 4; i++) begin
      c = ctl_ff[i / 2];
      pk = c[PACK_BIT] && (c[LEN_HI:LEN_LO] <= PACK_MAX_LEN_M1);
      d = RX_WORD[i].data & len_mask(c[LEN_HI:LEN_LO]);
      cmp_on[i] = c[MULTISLOT_ENABLE_BIT] && c[KEY_COMPARE_ENABLE_BIT] && csel_ff[i / 2][RX_WORD[i].slot];
      match[i] = ((d ^ key_ff[i / 2]) & ~kmask_ff[i / 2]) == 32'h0;
      acc[i] = RX_WORD[i].valid && (!cmp_on[i] || (match[i] == c[KEY_MATCH_POLARITY_BIT]));
      rej[i] = RX_WORD[i].valid && !acc[i];
      if (take_rx[i]) begin
        nxt_full[i] = 1'b0;
      end
      if (acc[i]) begin
        if (pk && !rx_half_ff[i]) begin
          nxt_half[i] = 1'b1;
          nxt_lo[i] = d[15:0];
        end else begin
          nxt_half[i] = 1'b0;
          if (!c[DMA_EN_BIT + i % 2]) begin
            rx_irq[i] = 1'b1;
          end else if (!rx_full_ff[i] || take_rx[i]) begin
            nxt_hold[i] = pk ? {d[15:0], rx_lo_ff[i]} : d;
            nxt_full[i] = 1'b1;
          end
        end
      end
      ct = ctl_ff[2 + i / 2];
      tpk = ct[PACK_BIT] && (ct[LEN_HI:LEN_LO] <= PACK_MAX_LEN_M1);
      if (TX_START[i] && !ct[DMA_EN_BIT + i % 2]) begin
        nxt_txhalf[i] = tpk && !tx_half_ff[i];
        tx_irq[i] = !tpk || tx_half_ff[i];
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      rx_hold_ff <= '{default: 32'h0};
      rx_lo_ff <= '{default: 16'h0};
      rx_full_ff <= 4'h0;
      rx_half_ff <= 4'h0;
      tx_half_ff <= 4'h0;
    end else begin
      rx_hold_ff <= nxt_hold;
      rx_lo_ff <= nxt_lo;
      rx_full_ff <= nxt_full;
      rx_half_ff <= nxt_half;
      tx_half_ff <= nxt_txhalf;
    end
  end

  // ****************************************
  // Arbitration, transfers, registers
  // ****************************************
  always_comb begin
    logic [6:0] pd;
    logic [7:0] a;
    logic [2:0] p;
    reg_wr_t w;
    pd = 7'h0;
    a = 8'h0;
    p = 3'h0;
    w = '0;
    for (int ch = 0; ch < NUM_SER; ch++) begin
      pend[ch] = ctl_ff[ch / 2][DMA_EN_BIT + ch % 2] && (par_ff[ch][PAR_COUNT] != 32'h0) &&
                 ((ch < 4) ? rx_full_ff[ch % 4] : (TX_READY[ch % 4] && !txload_ff[ch % 4]));
    end
    pend[9:8] = EP_REQ;
    pick = first_set(pend);
    p = pick[2:0];
    cur_idx = par_ff[p][PAR_INDEX];
    cur_step = par_ff[p][PAR_STEP];
    cur_cnt = par_ff[p][PAR_COUNT];
    nxt_par = par_ff;
    nxt_ctl = ctl_ff;
    nxt_key = key_ff;
    nxt_kmask = kmask_ff;
    nxt_csel = csel_ff;
    nxt_state = state_ff;
    nxt_fetch = fetch_ff;
    nxt_grant = 10'h000;
    nxt_mem = mem_ff;
    nxt_mem.req = 1'b0;
    nxt_txload = 4'h0;
    nxt_txdata = txdata_ff;
    nxt_irq = {tx_irq, rx_irq};
    take_rx = 4'h0;
    case (state_ff)
      ST_IDLE: begin
        if (|pend) begin
          nxt_grant = 10'h001 << pick;
          if (!pick[3]) begin
            nxt_mem.req = 1'b1;
            nxt_mem.we = !p[2];
            nxt_mem.addr = cur_idx;
            nxt_mem.wdata = rx_hold_ff[p[1:0]];
            nxt_par[p][PAR_INDEX] = cur_idx + cur_step;
            nxt_par[p][PAR_COUNT] = cur_cnt - 32'h1;
            if (cur_cnt == 32'h1) begin
              nxt_irq[p] = 1'b1;
              nxt_ctl[p[2:1]][DMA_EN_BIT + int'(p[0])] = 1'b0;
            end
            if (p[2]) begin
              nxt_state = ST_FETCH;
              nxt_fetch = p[1:0];
            end else begin
              take_rx[p[1:0]] = 1'b1;
            end
          end
        end
      end
      ST_FETCH: begin
        if (MEM_RVALID) begin
          nxt_txload[fetch_ff] = 1'b1;
          nxt_txdata = MEM_RDATA;
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // External write first so the core wins a same-address clash
    for (int k = 0; k < 2; k++) begin
      w = (k == 0) ? EXT_WR : CORE_WR;
      pd = par_dec(w.addr);
      a = w.addr;
      if (w.en) begin
        if (pd[6]) begin
          nxt_par[pd[5:3]][pd[2:0]] = w.data;
        end else if (a - CTL_ADDR < 8'h04) begin
          nxt_ctl[a[1:0]] = w.data;
        end else if (a - KEY_ADDR < 8'h02) begin
          nxt_key[a[0]] = w.data;
        end else if (a - KMASK_ADDR < 8'h02) begin
          nxt_kmask[a[0]] = w.data;
        end else if (a - CSEL_ADDR < 8'h02) begin
          nxt_csel[a[0]] = w.data;
        end
      end
    end
    pd = par_dec(RD_ADDR);
    a = RD_ADDR;
    nxt_rd = 32'h0;
    if (RD_EN) begin
      if (pd[6]) begin
        nxt_rd = par_ff[pd[5:3]][pd[2:0]];
      end else if (a - CTL_ADDR < 8'h04) begin
        nxt_rd = ctl_ff[a[1:0]];
      end else if (a - KEY_ADDR < 8'h02) begin
        nxt_rd = key_ff[a[0]];
      end else if (a - KMASK_ADDR < 8'h02) begin
        nxt_rd = kmask_ff[a[0]];
      end else if (a - CSEL_ADDR < 8'h02) begin
        nxt_rd = csel_ff[a[0]];
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      par_ff <= '{default: '{default: PAR_RST}};
      ctl_ff <= '{default: CTL_RST};
      key_ff <= '{default: KEY_RST};
      kmask_ff <= '{default: KMASK_RST};
      csel_ff <= '{default: CSEL_RST};
      state_ff <= ST_IDLE;
      fetch_ff <= 2'h0;
      grant_ff <= 10'h000;
      mem_ff <= '0;
      txload_ff <= 4'h0;
      txdata_ff <= 32'h0;
      irq_ff <= 8'h00;
      rd_ff <= 32'h0;
    end else begin
      par_ff <= nxt_par;
      ctl_ff <= nxt_ctl;
      key_ff <= nxt_key;
      kmask_ff <= nxt_kmask;
      csel_ff <= nxt_csel;
      state_ff <= nxt_state;
      fetch_ff <= nxt_fetch;
      grant_ff <= nxt_grant;
      mem_ff <= nxt_mem;
      txload_ff <= nxt_txload;
      txdata_ff <= nxt_txdata;
      irq_ff <= nxt_irq;
      rd_ff <= nxt_rd;
    end
  end

  assign RD_DATA = rd_ff;
  assign TX_LOAD = txload_ff;
  assign TX_DATA = txdata_ff;
  assign DMA_GRANT = grant_ff;
  assign MEM_REQ = mem_ff;
  assign CHAN_IRQ = irq_ff;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SYS_RST);

  logic fire, sw_any;
  assign fire = (state_ff == ST_IDLE) && (pend[7:0] != 8'h0);
  assign sw_any = CORE_WR.en || EXT_WR.en;

  a_serial_before_ep: assert property (fire |=> DMA_GRANT[9:8] == 2'b00)
    else $error("external channel granted over serial request");
  a_fixed_priority: assert property (|DMA_GRANT |-> $onehot(DMA_GRANT) &&
                                     (($past(pend) & (DMA_GRANT - 10'h001)) == 10'h000))
    else $error("grant is not the highest pending channel");
  a_addr_from_index: assert property (fire |=> MEM_REQ.req && MEM_REQ.addr == $past(cur_idx))
    else $error("transfer address is not the channel index");
  a_index_step: assert property (fire && !sw_any |=> par_ff[$past(pick[2:0])][PAR_INDEX] ==
                                 $past(cur_idx + cur_step))
    else $error("index did not advance by step");
  a_count_done: assert property (fire && !sw_any && cur_cnt == 32'h1 |=> CHAN_IRQ[$past(pick[2:0])] &&
                                 par_ff[$past(pick[2:0])][PAR_COUNT] == 32'h0 &&
                                 ((pend[7:0] & $past(8'h01 << pick[2:0])) == 8'h00))
    else $error("block end without interrupt or disable");
  a_match_accept: assert property (acc[0] && cmp_on[0] |-> match[0] == ctl_ff[0][KEY_MATCH_POLARITY_BIT])
    else $error("word accepted against key polarity");
  a_reject_quiet: assert property (rej[0] && !ctl_ff[0][DMA_EN_BIT] && !fire |=> !CHAN_IRQ[0] &&
                                   rx_full_ff[0] == $past(rx_full_ff[0]))
    else $error("rejected word had an effect");
  a_single_irq: assert property (acc[1] && !rx_half_ff[1] && !ctl_ff[0][DMA_EN_BIT + 1] &&
                                 !(ctl_ff[0][PACK_BIT] && ctl_ff[0][LEN_HI:LEN_LO] <= PACK_MAX_LEN_M1) |=> CHAN_IRQ[1])
    else $error("missing single-word receive interrupt");
  a_tx_fetch: assert property (state_ff == ST_FETCH && MEM_RVALID |=> TX_LOAD != 4'h0 &&
                               TX_DATA == $past(MEM_RDATA) ##1 TX_LOAD == 4'h0)
    else $error("fetched word not loaded for one cycle");
  c_rx_dma: cover property (fire && !pick[2] ##1 MEM_REQ.we);
  c_tx_dma: cover property (fire && pick[2] ##[1:8] TX_LOAD != 4'h0);
  c_key_reject: cover property (rej != 4'h0);
  c_ep_grant: cover property (DMA_GRANT[9:8] != 2'b00);

endmodule
`default_nettype wire

//--- verification/mem_responder.sv
/*
  Memory partner of the serial DMA channels: answers reads after a chosen delay.
  Assumes one read outstanding at a time and a one-cycle request pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module mem_responder
  import serial_dma_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // Memory port
  input wire mem_req_t MEM_REQ,
  input wire logic [3:0] DELAY,
  output logic [31:0] MEM_RDATA,
  output logic MEM_RVALID
);
  logic [31:0] rd_addr;
  logic [3:0] wait_cnt;
  logic busy;

  // ****************************************
  // Read answer, data toggles when not valid
  // ****************************************
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      busy <= 1'b0;
      MEM_RVALID <= 1'b0;
      MEM_RDATA <= 32'h00000000;
    end else if (MEM_REQ.req && !MEM_REQ.we) begin
      busy <= 1'b1;
      rd_addr <= MEM_REQ.addr;
      wait_cnt <= DELAY;
      MEM_RVALID <= 1'b0;
      MEM_RDATA <= ~MEM_RDATA;
    end else if (busy && wait_cnt == 4'h0) begin
      busy <= 1'b0;
      MEM_RVALID <= 1'b1;
      MEM_RDATA <= rd_addr ^ 32'h5A5A0000;
    end else begin
      if (busy) begin
        wait_cnt <= wait_cnt - 4'h1;
      end
      MEM_RVALID <= 1'b0;
      MEM_RDATA <= ~MEM_RDATA;
    end
  end
endmodule
`default_nettype wire

//--- verification/serial_dma_channels_tb.sv
/*
  Self-checking bench of the serial DMA channels: registers, receive and transmit DMA,
  key comparison, packing and priority. Assumes the memory partner in mem_responder.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_dma_channels_tb;
  import serial_dma_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  reg_wr_t core_wr = '0;
  reg_wr_t ext_wr = '0;
  logic rd_en = 1'b0;
  logic [7:0] rd_addr = 8'h00;
  logic [31:0] rd_data;
  rx_word_t [3:0] rx_word = '0;
  logic [3:0] tx_ready = 4'h0;
  logic [3:0] tx_start = 4'h0;
  logic [3:0] tx_load;
  logic [31:0] tx_data;
  logic [1:0] ep_req = 2'h0;
  logic [9:0] dma_grant;
  mem_req_t mem_req;
  logic [31:0] mem_rdata;
  logic mem_rvalid;
  logic [3:0] delay = 4'h0;
  logic [7:0] chan_irq;
  logic [7:0] irq_seen = 8'h00;
  int grants[$];
  int failures = 0;
  int samples_checked = 0;
  localparam logic [31:0] KC_CTL [6] = '{32'h1FE0, 32'h1FE0, 32'h1FE0, 32'h17E0, 32'h17E0, 32'h0FE0};
  localparam logic [4:0] KC_SLOT [6] = '{5'h00, 5'h00, 5'h01, 5'h00, 5'h00, 5'h00};
  localparam logic [31:0] KC_DATA [6] = '{32'hABCD1234, 32'hABCC1234, 32'h0, 32'hABCD0000, 32'h12345678, 32'h0};
  localparam logic KC_IRQ [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  localparam int PRIO [5] = '{0, 1, 2, 3, 8};

  always #4 sys_clk = ~sys_clk;

  serial_dma_channels uut (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .CORE_WR(core_wr), .EXT_WR(ext_wr),
    .RD_EN(rd_en), .RD_ADDR(rd_addr), .RD_DATA(rd_data), .RX_WORD(rx_word), .TX_READY(tx_ready),
    .TX_START(tx_start), .TX_LOAD(tx_load), .TX_DATA(tx_data), .EP_REQ(ep_req), .DMA_GRANT(dma_grant),
    .MEM_REQ(mem_req), .MEM_RDATA(mem_rdata), .MEM_RVALID(mem_rvalid), .CHAN_IRQ(chan_irq));
  mem_responder mem (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .MEM_REQ(mem_req), .DELAY(delay),
    .MEM_RDATA(mem_rdata), .MEM_RVALID(mem_rvalid));

  // ****************************************
  // Monitor of grants and interrupts
  // ****************************************
  always @(posedge sys_clk) begin
    irq_seen <= irq_seen | chan_irq;
    for (int i = 0; i < 10; i++) begin
      if (dma_grant[i] === 1'b1) begin
        grants.push_back(i);
      end
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic ext, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    if (ext) begin
      ext_wr <= {1'b1, a, d};
    end else begin
      core_wr <= {1'b1, a, d};
    end
    @(posedge sys_clk);
    ext_wr <= '0;
    core_wr <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    chk(rd_data, exp);
  endtask

  task automatic rx(input int ch, input logic [4:0] slot, input logic [31:0] d);
    @(posedge sys_clk);
    rx_word[ch] <= {1'b1, slot, d};
    @(posedge sys_clk);
    rx_word[ch] <= '0;
  endtask

  task automatic irq_chk(input int ch, input logic exp);
    repeat (4) @(posedge sys_clk);
    #1;
    chk({31'h0, irq_seen[ch]}, {31'h0, exp});
    irq_seen = 8'h00;
  endtask

  task automatic wait_mem(input logic we, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (mem_req.req !== 1'b1 && n < 40);
    if (n == 40) begin
      failures++;
      summarize();
    end
    chk({31'h0, mem_req.we}, {31'h0, we});
    chk(mem_req.addr, a);
    if (we) begin
      chk(mem_req.wdata, d);
    end
  endtask

  task automatic tx(input int ch, input logic [31:0] a);
    int n;
    @(posedge sys_clk);
    tx_ready[ch] <= 1'b1;
    wait_mem(1'b0, a, 32'h0);
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (tx_load[ch] !== 1'b1 && n < 40);
    tx_ready[ch] <= 1'b0;
    if (n == 40) begin
      failures++;
      summarize();
    end
    chk(tx_data, a ^ 32'h5A5A0000);
  endtask

  task automatic start(input int ch);
    @(posedge sys_clk);
    tx_start[ch] <= 1'b1;
    @(posedge sys_clk);
    tx_start[ch] <= 1'b0;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    summarize();
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(CTL_ADDR, CTL_RST);
    rd(PAR_BASE[0] + PAR_COUNT, PAR_RST);
    wr(1'b1, 8'h35, 32'hFFFFFFFF);
    rd(8'h35, 32'h0);
    wr(1'b1, PAR_BASE[7] + PAR_SPARE, 32'hCAFE0001);
    rd(PAR_BASE[7] + PAR_SPARE, 32'hCAFE0001);
    wr(1'b0, PAR_BASE[3] + PAR_CHAIN, 32'h00001234);
    rd(PAR_BASE[3] + PAR_CHAIN, 32'h00001234);
    wr(1'b1, 8'h03, 32'h0000000C);
    rd(8'h03, 32'h0000000C);
    // Receive block of two words
    wr(1'b0, PAR_BASE[0] + PAR_INDEX, 32'h100);
    wr(1'b1, PAR_BASE[0] + PAR_STEP, 32'h2);
    wr(1'b0, PAR_BASE[0] + PAR_COUNT, 32'h2);
    wr(1'b0, 8'h00, CTL_RST | 32'h1);
    rx(0, 5'h00, 32'h11110001);
    wait_mem(1'b1, 32'h100, 32'h11110001);
    irq_chk(0, 1'b0);
    rx(0, 5'h00, 32'h22220002);
    wait_mem(1'b1, 32'h102, 32'h22220002);
    irq_chk(0, 1'b1);
    rd(PAR_BASE[0] + PAR_INDEX, 32'h104);
    rd(PAR_BASE[0] + PAR_COUNT, 32'h0);
    rd(8'h00, CTL_RST);
    // Key comparison with DMA off
    wr(1'b0, KEY_ADDR, 32'hABCD0000);
    wr(1'b0, KMASK_ADDR, 32'h0000FFFF);
    wr(1'b0, CSEL_ADDR, 32'h00000001);
    for (int k = 0; k < 6; k++) begin
      wr(1'b0, 8'h00, KC_CTL[k]);
      irq_seen = 8'h00;
      // Last case runs on channel B of the same port
      rx(k / 5, KC_SLOT[k], KC_DATA[k]);
      irq_chk(k / 5, KC_IRQ[k]);
    end
    // Same-cycle requests
    for (int i = 0; i < 4; i++) begin
      wr(1'b0, PAR_BASE[i] + PAR_INDEX, 32'h400 + i);
      wr(1'b0, PAR_BASE[i] + PAR_COUNT, 32'h1);
    end
    wr(1'b0, 8'h00, CTL_RST | 32'h3);
    wr(1'b0, 8'h01, CTL_RST | 32'h3);
    @(posedge sys_clk);
    grants.delete();
    irq_seen = 8'h00;
    for (int i = 0; i < 4; i++) begin
      rx_word[i] <= {1'b1, 5'h00, 32'h0};
    end
    @(posedge sys_clk);
    rx_word <= '0;
    ep_req <= 2'h3;
    repeat (20) @(posedge sys_clk);
    ep_req <= 2'h0;
    chk(grants.size() > 4, 32'h1);
    for (int i = 0; i < 5; i++) begin
      chk(grants[i], PRIO[i]);
    end
    irq_chk(3, 1'b1);
    // Transmit block with decrementing index
    wr(1'b0, PAR_BASE[4] + PAR_INDEX, 32'h200);
    wr(1'b1, PAR_BASE[4] + PAR_STEP, 32'hFFFFFFFF);
    wr(1'b0, PAR_BASE[4] + PAR_COUNT, 32'h2);
    wr(1'b0, 8'h02, CTL_RST | 32'h1);
    tx(0, 32'h200);
    irq_chk(4, 1'b0);
    delay <= 4'h3;
    tx(0, 32'h1FF);
    irq_chk(4, 1'b1);
    rd(PAR_BASE[4] + PAR_COUNT, 32'h0);
    // Single-word transmit, plain and packed
    wr(1'b0, 8'h02, CTL_RST);
    start(1);
    irq_chk(5, 1'b1);
    wr(1'b0, 8'h02, 32'h1F0);
    start(1);
    irq_chk(5, 1'b0);
    start(1);
    irq_chk(5, 1'b1);
    // Receive packing and short words
    wr(1'b0, PAR_BASE[2] + PAR_INDEX, 32'h300);
    wr(1'b0, PAR_BASE[2] + PAR_COUNT, 32'h1);
    wr(1'b0, 8'h01, 32'h1F1);
    rx(2, 5'h00, 32'h1111);
    irq_chk(2, 1'b0);
    rx(2, 5'h00, 32'h2222);
    wait_mem(1'b1, 32'h300, 32'h22221111);
    irq_chk(2, 1'b1);
    wr(1'b0, PAR_BASE[2] + PAR_INDEX, 32'h310);
    wr(1'b0, PAR_BASE[2] + PAR_COUNT, 32'h1);
    wr(1'b0, 8'h01, 32'h41);
    rx(2, 5'h00, 32'hFFFFFFFD);
    wait_mem(1'b1, 32'h310, 32'h5);
    summarize();
  end
endmodule
`default_nettype wire
